/* File: hw/gesr_pkg.sv */
// gesr_pkg: shared types and constants for the emergency stop and reset pin-state block
// assumes a single 10 MHz system clock domain; no register bus
package gesr_pkg;
  localparam int unsigned NUM_PINS       = 16;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam int unsigned CLK_MHZ        = 10;
  localparam int unsigned IRST_TIME_US   = 10;
  localparam int unsigned IRST_CYCLES    = IRST_TIME_US * CLK_MHZ;
  localparam int unsigned IRST_CNT_W     = 8;
  localparam logic        SRC_SEL_A      = 1'b0;
  localparam logic        STRAP_PULLUP   = 1'b1;

  // per-pin capability flags set at integration time
  typedef struct packed {
    logic gpo_capable;    // has a general output function
    logic input_only;     // input-only or analog-overlaid input
    logic reg_pin;        // switching-regulator pin
    logic port0_adc;      // pin of port 00, analog converter may overrule
    logic dbg_can;        // debug-over-can pin
    logic jtag_tdi;       // may serve as test data input
    logic dbg_clk;        // debug clock-capable pin
  } gesr_pin_cap_s;

  // pad control toward one pin
  typedef struct packed {
    logic out_en;
    logic pull_up;
    logic pull_down;
  } gesr_pad_s;

  typedef struct packed {
    logic jtag_mode;
    logic tdi_in_use;
    logic three_pin_mode;
    logic can_phy_mode;
    logic can_msg_mode;
  } gesr_dbg_s;

  typedef enum logic [1:0] {
    GESR_IN_RESET,
    GESR_INT_RESET,
    GESR_RUN
  } gesr_phase_e;
endpackage

/* File: hw/gesr_core.sv */
// gesr_core: emergency stop forcing and reset pull state of general purpose pins
// assumes all inputs synchronous to clock, except the stop inputs which are synchronised here
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R01 - enabled pins forced to input during stop; pull-up or high-z per latched strap
// R02 - global enable switches whole stop function on or off
// R03 - select picks stop input a or b as trigger
// R04 - per-pin enable bits choose pins taking part in forcing
// R05 - no forcing on input-only, analog, regulator-mode or output-less pins
// R06 - port 00 analog overrule, disable bit in special control removes it
// R07 - debug-over-can pins overruled in phy mode, not in message mode
// R08 - tdi pin ignores stop while jtag uses it as data input
// R09 - debug clock pin ignores stop in jtag or three-pin debug mode
// R10 - during power-on reset pins pull up if strap 1, high-z if 0
// R11 - strap pin has weak pull-up from start-up
// R12 - strap low: pins high-z; fixed pin high-z, analog port input disabled
// R13 - jtag reset pull-down off in leakage test, always on with test-mode 1
// R14 - service request 0 driven low during power-on reset, pulled up after
// R15 - service request 0 low continues until internal reset phase ends
// R16 - jtag data out pulled up in reset, after it high-z or pull-up per selection
// R17 - power-on reset pull-down on whenever supply monitor reports violation
// R18 - stop input synchronised; forcing releases when input drops or disabled
module gesr_core
  import gesr_pkg::*;
#(
  parameter int unsigned IRST_LEN = IRST_CYCLES
) (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire logic                          power_on_reset_n,
  input  wire logic                          pin_default_strap,
  input  wire logic                          emergency_stop_input_a,
  input  wire logic                          emergency_stop_input_b,
  input  wire logic                          stop_global_enable,
  input  wire logic                          stop_source_select,
  input  wire logic [gesr_pkg::NUM_PINS-1:0] port_emergency_stop_enable,
  input  wire logic                          port0_special_control,
  input  wire logic                          analog_converter_unit_req,
  input  wire logic                          regulator_mode,
  input  wire logic                          test_mode_pin,
  input  wire logic                          supply_violation,
  input  wire logic                          tdo_pullup_select,
  input  wire gesr_pkg::gesr_dbg_s           dbg,
  input  wire gesr_pkg::gesr_pin_cap_s [gesr_pkg::NUM_PINS-1:0] pin_cap,
  input  wire gesr_pkg::gesr_pad_s     [gesr_pkg::NUM_PINS-1:0] user_pad,
  output var  gesr_pkg::gesr_pad_s     [gesr_pkg::NUM_PINS-1:0] pad,
  output logic                               strap_pull_up,
  output logic                               jtag_reset_pull_down,
  output logic                               service_request_pin_0_low,
  output logic                               service_request_pin_0_pull_up,
  output logic                               service_request_pin_1_pull_up,
  output logic                               tdo_pull_up,
  output logic                               por_strong_pull_down,
  output logic                               stop_active
);
  import gesr_pkg::*;

  logic [SYNC_STAGES-1:0] sync_a;
  logic [SYNC_STAGES-1:0] sync_b;
  logic                   strap_latched;
  gesr_phase_e            phase;
  gesr_phase_e            next_phase;
  logic [IRST_CNT_W-1:0]  irst_cnt;
  logic [IRST_CNT_W-1:0]  next_irst_cnt;
  logic                   tdo_sel;
  logic                   next_stop;

  wire in_por     = !power_on_reset_n;
  wire irst_done  = (irst_cnt >= IRST_CNT_W'(IRST_LEN - 1));
  wire stop_src   = (stop_source_select == SRC_SEL_A) ? sync_a[SYNC_STAGES-1]
                                                      : sync_b[SYNC_STAGES-1]; // R03
  wire strap_now  = in_por ? pin_default_strap : strap_latched;
  wire in_reset   = in_por | (phase != GESR_RUN);
  wire leak_test  = in_por & !test_mode_pin;
  // one net per pin, gathered into a single pad register so no pin has its own driver process
  wire gesr_pad_s [NUM_PINS-1:0] next_pad;

  // only the last stage is read; first stage feeds nothing else
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {sync_a[SYNC_STAGES-2:0], emergency_stop_input_a}; // R18
      sync_b <= {sync_b[SYNC_STAGES-2:0], emergency_stop_input_b}; // R18
    end
  end

  // release on input drop or disable, no latching of the stop
  assign next_stop = stop_global_enable & stop_src; // R02 R18

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stop_active <= 1'b0;
    end else begin
      stop_active <= next_stop;
    end
  end

  // strap sampled each clock while reset is held, frozen at release
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      strap_latched <= STRAP_PULLUP;
    end else if (in_por) begin
      strap_latched <= pin_default_strap; // R01 R10
    end
  end

  // tdo selection sampled while in power-on or internal reset phase
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tdo_sel <= 1'b1;
    end else if (phase != GESR_RUN) begin
      tdo_sel <= tdo_pullup_select; // R16
    end
  end

  always_comb begin
    next_phase    = phase;
    next_irst_cnt = irst_cnt;
    unique case (phase)
      GESR_IN_RESET: begin
        next_irst_cnt = '0;
        if (!in_por) begin
          next_phase = GESR_INT_RESET;
        end
      end
      GESR_INT_RESET: begin
        next_irst_cnt = irst_cnt + IRST_CNT_W'(1);
        if (irst_done) begin
          next_phase = GESR_RUN;
        end
      end
      GESR_RUN: begin
        next_irst_cnt = '0;
      end
    endcase
    if (in_por) begin
      next_phase = GESR_IN_RESET;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      phase    <= GESR_IN_RESET;
      irst_cnt <= '0;
    end else begin
      phase    <= next_phase;
      irst_cnt <= next_irst_cnt;
    end
  end

  // per-pin forcing and reset defaults
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    wire excluded  = pin_cap[i].input_only | !pin_cap[i].gpo_capable
                   | (pin_cap[i].reg_pin & regulator_mode); // R05
    wire ov_adc    = pin_cap[i].port0_adc & analog_converter_unit_req
                   & !port0_special_control; // R06
    wire ov_can    = pin_cap[i].dbg_can & dbg.can_phy_mode & !dbg.can_msg_mode; // R07
    wire ov_tdi    = pin_cap[i].jtag_tdi & dbg.jtag_mode & dbg.tdi_in_use; // R08
    wire ov_clk    = pin_cap[i].dbg_clk & (dbg.jtag_mode | dbg.three_pin_mode); // R09
    wire overrule  = ov_adc | ov_can | ov_tdi | ov_clk;
    wire forced    = stop_active & port_emergency_stop_enable[i]
                   & !excluded & !overrule; // R01 R04
    // reset default: analog/input-only pins keep their digital input off, no pull
    wire rst_pu    = strap_now & !pin_cap[i].input_only; // R10 R12
    wire gesr_pad_s rst_val   = '{out_en: 1'b0, pull_up: rst_pu, pull_down: 1'b0}; // R10 R12
    wire gesr_pad_s force_val = '{out_en: 1'b0, pull_up: strap_latched, pull_down: 1'b0}; // R01
    // reset outranks stop: pads hold the strap default until the run phase
    assign next_pad[i] = in_reset ? rst_val : (forced ? force_val : user_pad[i]);
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pad <= '0;
    end else begin
      pad <= next_pad;
    end
  end

  // strap pull-up is a fixed start-up default, never released here
  assign strap_pull_up                 = 1'b1; // R11
  assign jtag_reset_pull_down          = !leak_test; // R13
  assign service_request_pin_0_low     = in_reset; // R14 R15
  assign service_request_pin_0_pull_up = !service_request_pin_0_low; // R14
  assign service_request_pin_1_pull_up = 1'b1;
  assign tdo_pull_up                   = in_por | tdo_sel; // R16
  assign por_strong_pull_down          = supply_violation | in_por; // R17
endmodule

`default_nettype wire

/* File: tb/gesr_core_asserts.sv */
// gesr_core_asserts: port timing checks of the pin-state block
// assumes bind onto gesr_core; pin 0 seen as a plain output pin
`timescale 1ns/1ps
`default_nettype none
module gesr_core_asserts
  import gesr_pkg::*;
#(
  parameter int unsigned IRST_LEN = IRST_CYCLES
) (
  input wire logic                    clock,
  input wire logic                    rst_b,
  input wire logic                    power_on_reset_n,
  input wire logic                    pin_default_strap,
  input wire logic                    emergency_stop_input_a,
  input wire logic                    stop_global_enable,
  input wire logic                    stop_source_select,
  input wire logic                    test_mode_pin,
  input wire logic                    supply_violation,
  input wire gesr_pkg::gesr_pin_cap_s [gesr_pkg::NUM_PINS-1:0] pin_cap,
  input wire gesr_pkg::gesr_pad_s     [gesr_pkg::NUM_PINS-1:0] pad,
  input wire logic                    jtag_reset_pull_down,
  input wire logic                    service_request_pin_0_low,
  input wire logic                    tdo_pull_up,
  input wire logic                    por_strong_pull_down,
  input wire logic                    stop_active
);
  // margin over the internal phase for sync and state latency
  localparam int IRST_MAX = IRST_LEN + 8;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence stop_a_held;
    (stop_global_enable && !stop_source_select && emergency_stop_input_a
     && power_on_reset_n && !service_request_pin_0_low) [*3];
  endsequence
  sequence int_phase;
    service_request_pin_0_low [*3] ##[1:IRST_MAX] !service_request_pin_0_low;
  endsequence
  stop_rise_a: assert property (stop_a_held |=> stop_active)
    else $error("stop not active three edges after input");
  stop_enable_a: assert property (!stop_global_enable [*2] |-> !stop_active)
    else $error("stop active while disabled");
  src_select_a: assert property ((!stop_source_select && !emergency_stop_input_a) [*4]
    |-> !stop_active)
    else $error("stop active from unselected input");
  por_pad_a: assert property ((!power_on_reset_n && !pin_cap[0].input_only
    && $stable(pin_default_strap)) [*2] |-> pad[0] == {1'b0, pin_default_strap, 1'b0})
    else $error("pad state wrong during power-on reset");
  sr0_low_a: assert property (!power_on_reset_n [*2] |-> service_request_pin_0_low)
    else $error("service request 0 not low in reset");
  sr0_hold_a: assert property ($rose(power_on_reset_n) |-> int_phase)
    else $error("service request 0 phase length wrong");
  trst_leak_a: assert property ((!power_on_reset_n && !test_mode_pin) [*2]
    |-> !jtag_reset_pull_down)
    else $error("jtag reset pull-down on in leakage test");
  trst_on_a: assert property (test_mode_pin [*2] |-> jtag_reset_pull_down)
    else $error("jtag reset pull-down off in test mode");
  por_pd_a: assert property (supply_violation [*2] |-> por_strong_pull_down)
    else $error("reset pull-down off on supply violation");
  tdo_por_a: assert property (!power_on_reset_n [*2] |-> tdo_pull_up)
    else $error("data out not pulled up in reset");
endmodule
`default_nettype wire

/* File: tb/gesr_board.sv */
// gesr_board: stop sources and strap wiring on the board
// assumes the bench sets request levels just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module gesr_board (
  input  wire logic stop_a_req,
  input  wire logic stop_b_req,
  input  wire logic strap_grounded,
  output logic      emergency_stop_input_a,
  output logic      emergency_stop_input_b,
  output logic      pin_default_strap
);
  assign emergency_stop_input_a = stop_a_req;
  assign emergency_stop_input_b = stop_b_req;
  // open strap floats high through the weak pull-up
  assign pin_default_strap = strap_grounded ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// tb_top: self-checking bench of gesr_core with board model
// assumes 10 MHz clock and a shortened internal reset phase
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gesr_pkg::*;
  localparam int unsigned IRST = 4;
  logic clock, rst_b, power_on_reset_n, pin_default_strap, emergency_stop_input_a;
  logic emergency_stop_input_b, stop_global_enable, stop_source_select, port0_special_control;
  logic analog_converter_unit_req, regulator_mode, test_mode_pin, supply_violation;
  logic tdo_pullup_select, strap_pull_up, jtag_reset_pull_down, service_request_pin_0_low;
  logic service_request_pin_0_pull_up, service_request_pin_1_pull_up, tdo_pull_up;
  logic por_strong_pull_down, stop_active, a_req, b_req, gnd;
  logic [NUM_PINS-1:0] port_emergency_stop_enable;
  gesr_dbg_s dbg;
  gesr_pin_cap_s [NUM_PINS-1:0] pin_cap;
  gesr_pad_s [NUM_PINS-1:0] user_pad, pad;
  int errors, comparisons;
  // en sel a b regm adc scr | dbg | stop | forced mask
  logic [28:0] rows [12] = '{{7'h10, 5'h00, 1'h0, 16'h0000}, {7'h50, 5'h00, 1'h1, 16'hfef5},
    {7'h48, 5'h00, 1'h0, 16'h0000}, {7'h68, 5'h00, 1'h1, 16'hfef5},
    {7'h56, 5'h00, 1'h1, 16'hfee1}, {7'h53, 5'h00, 1'h1, 16'hfef5},
    {7'h50, 5'h02, 1'h1, 16'hfed5}, {7'h50, 5'h01, 1'h1, 16'hfef5},
    {7'h50, 5'h10, 1'h1, 16'hfe75}, {7'h50, 5'h18, 1'h1, 16'hfe35},
    {7'h50, 5'h04, 1'h1, 16'hfe75}, {7'h40, 5'h00, 1'h0, 16'h0000}};
  gesr_board i_gesr_board (.stop_a_req(a_req), .stop_b_req(b_req), .strap_grounded(gnd),
    .emergency_stop_input_a, .emergency_stop_input_b, .pin_default_strap);
  gesr_core #(.IRST_LEN(IRST)) i_gesr_core (.*);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pads(input logic [15:0] mask, input logic [2:0] forced);
    for (int i = 0; i < NUM_PINS; i++) begin
      check("pad", 16'(pad[i]), mask[i] ? 16'(forced) : 16'(user_pad[i]));
    end
  endtask
  task automatic conclude();
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {rst_b, power_on_reset_n, a_req, b_req, gnd, stop_global_enable, stop_source_select} = '0;
    {port0_special_control, analog_converter_unit_req, regulator_mode, supply_violation} = '0;
    {test_mode_pin, tdo_pullup_select, dbg} = '0;
    port_emergency_stop_enable = 16'hfeff;
    user_pad = {NUM_PINS{3'h5}};
    pin_cap = {{8{7'h40}}, 7'h41, 7'h42, 7'h44, 7'h48, 7'h00, 7'h50, 7'h20, 7'h40};
    tick(16);
    rst_b = 1'b1;
    tick(3);
    check("por pad", 16'({pad[1], pad[0]}), 16'h02);
    check("tdo pu", 16'(tdo_pull_up), 16'h1);
    check("trst leak", 16'(jtag_reset_pull_down), 16'h0);
    test_mode_pin = 1'b1;
    supply_violation = 1'b1;
    tick(2);
    check("trst pd", 16'(jtag_reset_pull_down), 16'h1);
    check("por pd", 16'(por_strong_pull_down), 16'h1);
    check("fixed pu", 16'({strap_pull_up, service_request_pin_1_pull_up}), 16'h3);
    power_on_reset_n = 1'b1;
    tick(2);
    check("sr0 hold", 16'(service_request_pin_0_low), 16'h1);
    tick(IRST + 4);
    check("sr0 end", 16'({service_request_pin_0_low, service_request_pin_0_pull_up}), 16'h1);
    check("violation pd", 16'(por_strong_pull_down), 16'h1);
    check("tdo run", 16'(tdo_pull_up), 16'h0);
    supply_violation = 1'b0;
    tick(1);
    check("supply ok pd", 16'(por_strong_pull_down), 16'h0);
    foreach (rows[r]) begin
      {stop_global_enable, stop_source_select, a_req, b_req, regulator_mode,
        analog_converter_unit_req, port0_special_control, dbg} = rows[r][28:17];
      tick(6);
      check("stop", 16'(stop_active), 16'(rows[r][16]));
      pads(rows[r][15:0], 3'h2);
    end
    // second reset with strap grounded, stop raised inside it
    {gnd, power_on_reset_n, a_req} = 3'h5;
    tdo_pullup_select = 1'b1;
    tick(3);
    check("por low", 16'({pad[0], stop_active}), 16'h1);
    {gnd, power_on_reset_n} = 2'h1;
    tick(IRST + 8);
    pads(16'hfef5, 3'h0);
    check("tdo select", 16'(tdo_pull_up), 16'h1);
    conclude();
  end
  initial begin
    repeat (2000) @(posedge clock);
    errors++;
    conclude();
  end
endmodule
bind gesr_core gesr_core_asserts #(.IRST_LEN(IRST_LEN)) i_gesr_core_asserts (.*);
`default_nettype wire
